// *** core/rpsr_pkg.sv ***
package rpsr_pkg;

  // Register offsets
  localparam logic [7:0] ADDR_PACKET_LINE_STATUS   = 8'h38;
  localparam logic [7:0] ADDR_RECEIVE_QUEUE_STATUS = 8'h3B;
  localparam logic [7:0] ADDR_IRQ_STATUS           = 8'h40;
  localparam logic [7:0] ADDR_IRQ_MASK             = 8'h41;

  // Packet status bit positions
  localparam int BIT_CHECKSUM_OK  = 7;
  localparam int BIT_CARRIER      = 6;
  localparam int BIT_RSVD_HI      = 5;
  localparam int BIT_RSVD_LO      = 4;
  localparam int BIT_FRAME_START  = 3;
  localparam int BIT_OUTPUT_TWO   = 2;
  localparam int BIT_UNUSED       = 1;
  localparam int BIT_OUTPUT_ZERO  = 0;

  // Queue status layout
  localparam int BIT_QUEUE_OVERRUN = 7;
  localparam int QUEUE_COUNT_W     = 7;

  // Fixed value of the reserved pair, bits 5:4
  localparam logic [1:0] RSVD_VALUE = 2'h0;

  // Interrupt status / mask layout
  localparam int IRQ_W           = 4;
  localparam int IRQ_CHECKSUM_OK = 0;
  localparam int IRQ_FRAME_START = 1;
  localparam int IRQ_OVERRUN     = 2;
  localparam int IRQ_FRAME_DROP  = 3;

  localparam logic [7:0]       ZERO_BYTE   = 8'h00;
  localparam logic [IRQ_W-1:0] IRQ_RESET   = 4'h0;

endpackage : rpsr_pkg

// *** core/rpsr_status_regs.sv ***
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
// Summary of operation
// - Bit 7: checksum match, cleared entering receive
// - Bit 6: carrier detect, cleared on idle
// - Bit 3: set at sync word, cleared at end
// - Bit 3 also cleared on drop or overrun
// - Bit 2: non-inverted level of output two
// - Bit 0: non-inverted level of output zero
// - Queue register: overrun bit 7, count 6:0
module rpsr_status_regs
(
  input  wire logic       clk,              // 20 MHz clock
  input  wire logic       reset,            // Async reset, active high
  input  wire logic [7:0] addr,             // Register address
  input  wire logic [7:0] wdata,            // Write data
  input  wire logic       wr,               // Write strobe
  input  wire logic       rd,               // Read strobe
  output logic      [7:0] rdata,            // Read data, cycle after rd
  output logic            irq,              // Level interrupt
  input  wire logic       checksum_done,    // Checksum compared, pulse
  input  wire logic       checksum_match,   // Result with checksum_done
  input  wire logic       rx_enter,         // Receive entered/restarted
  input  wire logic       carrier_detect,   // Demodulator carrier level
  input  wire logic       radio_idle_enter, // Radio entered idle, pulse
  input  wire logic       sync_found,       // Sync word received, pulse
  input  wire logic       packet_end,       // Packet ended, pulse
  input  wire logic       packet_drop,      // Address/length drop, pulse
  input  wire logic       receive_queue_overrun, // Overrun state level
  input  wire logic [6:0] receive_queue_count,   // Bytes in queue
  input  wire logic       general_output_two,    // Pin level, pre-invert
  input  wire logic       general_output_zero    // Pin level, pre-invert
);

  localparam int IRQ_W = rpsr_pkg::IRQ_W;

  logic             checksum_ok;
  logic             next_checksum_ok;
  logic             carrier;
  logic             next_carrier;
  logic             frame_start_flag;
  logic             next_frame_start_flag;
  logic             overrun_q;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] next_irq_status;
  logic [IRQ_W-1:0] irq_mask;
  logic [IRQ_W-1:0] next_irq_mask;
  logic [7:0]       next_rdata;
  logic [IRQ_W-1:0] irq_event;
  logic             overrun_rise;

  // Pin levels come from outside the clock domain
  logic [1:0] pin_two_sync;
  logic [1:0] pin_zero_sync;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  always_comb
  begin
    next_checksum_ok = checksum_ok;
    if (rx_enter)
      next_checksum_ok = 1'b0;
    else if (checksum_done)
      next_checksum_ok = checksum_match;
    // Carrier follows the demodulator except in the idle-entry cycle
    next_carrier = radio_idle_enter ? 1'b0 : carrier_detect;
    next_frame_start_flag = frame_start_flag;
    if (packet_end || packet_drop || receive_queue_overrun)
      next_frame_start_flag = 1'b0;
    else if (sync_found)
      next_frame_start_flag = 1'b1;
  end

  assign overrun_rise = receive_queue_overrun && !overrun_q;
  assign irq_event[rpsr_pkg::IRQ_CHECKSUM_OK] = checksum_done
                                               && checksum_match;
  assign irq_event[rpsr_pkg::IRQ_FRAME_START] = sync_found
                                               && !frame_start_flag;
  assign irq_event[rpsr_pkg::IRQ_OVERRUN]     = overrun_rise;
  assign irq_event[rpsr_pkg::IRQ_FRAME_DROP]  = packet_drop;

  always_comb
  begin
    next_irq_mask   = irq_mask;
    next_irq_status = irq_status;
    if (wr && hit(addr, rpsr_pkg::ADDR_IRQ_MASK))
      next_irq_mask = wdata[IRQ_W-1:0];
    if (wr && hit(addr, rpsr_pkg::ADDR_IRQ_STATUS))
      next_irq_status = irq_status & ~wdata[IRQ_W-1:0];
    // A new event wins over a same-cycle clear
    next_irq_status = next_irq_status | irq_event;
  end

  // Packet and queue status registers ignore writes; only rd decodes them
  always_comb
  begin
    next_rdata = rpsr_pkg::ZERO_BYTE;
    if (rd)
    begin
      if (hit(addr, rpsr_pkg::ADDR_PACKET_LINE_STATUS))
      begin
        next_rdata[rpsr_pkg::BIT_CHECKSUM_OK] = checksum_ok;
        next_rdata[rpsr_pkg::BIT_CARRIER]     = carrier;
        next_rdata[rpsr_pkg::BIT_RSVD_HI:rpsr_pkg::BIT_RSVD_LO] =
          rpsr_pkg::RSVD_VALUE;
        next_rdata[rpsr_pkg::BIT_FRAME_START] = frame_start_flag;
        next_rdata[rpsr_pkg::BIT_OUTPUT_TWO]  = pin_two_sync[1];
        next_rdata[rpsr_pkg::BIT_UNUSED]      = 1'b0;
        next_rdata[rpsr_pkg::BIT_OUTPUT_ZERO] = pin_zero_sync[1];
      end
      else if (hit(addr, rpsr_pkg::ADDR_RECEIVE_QUEUE_STATUS))
      begin
        next_rdata[rpsr_pkg::BIT_QUEUE_OVERRUN] = receive_queue_overrun;
        next_rdata[rpsr_pkg::QUEUE_COUNT_W-1:0] = receive_queue_count;
      end
      else if (hit(addr, rpsr_pkg::ADDR_IRQ_STATUS))
        next_rdata[IRQ_W-1:0] = irq_status;
      else if (hit(addr, rpsr_pkg::ADDR_IRQ_MASK))
        next_rdata[IRQ_W-1:0] = irq_mask;
    end
  end

  // Receiver status flags
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      checksum_ok      <= 1'b0;
      carrier          <= 1'b0;
      frame_start_flag <= 1'b0;
      overrun_q        <= 1'b0;
    end
    else
    begin
      checksum_ok      <= next_checksum_ok;
      carrier          <= next_carrier;
      frame_start_flag <= next_frame_start_flag;
      overrun_q        <= receive_queue_overrun;
    end
  end

  // Interrupt status and mask
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      irq_status <= rpsr_pkg::IRQ_RESET;
      irq_mask   <= rpsr_pkg::IRQ_RESET;
    end
    else
    begin
      irq_status <= next_irq_status;
      irq_mask   <= next_irq_mask;
    end
  end

  // Read data stands one cycle, so a stale value never lingers on the bus
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      rdata <= rpsr_pkg::ZERO_BYTE;
    end
    else
    begin
      rdata <= next_rdata;
    end
  end

  // Pin value is sampled before inversion, so bits read true level
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      pin_two_sync  <= 2'h0;
      pin_zero_sync <= 2'h0;
    end
    else
    begin
      pin_two_sync  <= {pin_two_sync[0], general_output_two};
      pin_zero_sync <= {pin_zero_sync[0], general_output_zero};
    end
  end

  assign irq = |(irq_status & irq_mask);

  // Reads are checked one cycle after the strobe, so each expected
  // value is the input as it stood when the strobe was taken, but two cycles earlier for the pin bits
  chk_checksum_clear: assert property (
    @(posedge clk) disable iff (reset)
    rx_enter |=> !checksum_ok)
    else $error("checksum bit not cleared on receive entry");

  chk_checksum_set: assert property (
    @(posedge clk) disable iff (reset)
    checksum_done && checksum_match && !rx_enter |=> checksum_ok)
    else $error("checksum bit not set on match");

  chk_checksum_fail: assert property (
    @(posedge clk) disable iff (reset)
    checksum_done && !checksum_match |=> !checksum_ok)
    else $error("checksum bit still set after failed compare");

  chk_carrier_idle: assert property (
    @(posedge clk) disable iff (reset)
    radio_idle_enter |=> !carrier)
    else $error("carrier bit not cleared on idle");

  chk_carrier_follow: assert property (
    @(posedge clk) disable iff (reset)
    !radio_idle_enter |=> carrier == $past(carrier_detect))
    else $error("carrier bit does not follow detector");

  // Frame start tracking
  chk_frame_start_set: assert property (
    @(posedge clk) disable iff (reset)
    sync_found && !packet_end && !packet_drop && !receive_queue_overrun
    |=> frame_start_flag)
    else $error("frame start not set on sync");

  chk_frame_start_end: assert property (
    @(posedge clk) disable iff (reset)
    packet_end |=> !frame_start_flag)
    else $error("frame start not cleared at packet end");

  chk_frame_start_hold: assert property (
    @(posedge clk) disable iff (reset)
    !sync_found && !packet_end && !packet_drop && !receive_queue_overrun
    |=> $stable(frame_start_flag))
    else $error("frame start changed with no event");

  chk_frame_start_drop: assert property (
    @(posedge clk) disable iff (reset)
    packet_drop || receive_queue_overrun |=> !frame_start_flag)
    else $error("frame start not cleared on drop or overrun");

  // Register reads
  chk_output_two_level: assert property (
    @(posedge clk) disable iff (reset)
    rd && addr == rpsr_pkg::ADDR_PACKET_LINE_STATUS
    |=> rdata[rpsr_pkg::BIT_OUTPUT_TWO] == $past(general_output_two, 3))
    else $error("output two level wrong");

  chk_output_zero_level: assert property (
    @(posedge clk) disable iff (reset)
    rd && addr == rpsr_pkg::ADDR_PACKET_LINE_STATUS
    |=> rdata[rpsr_pkg::BIT_OUTPUT_ZERO] == $past(general_output_zero, 3))
    else $error("output zero level wrong");

  chk_queue_read: assert property (
    @(posedge clk) disable iff (reset)
    rd && addr == rpsr_pkg::ADDR_RECEIVE_QUEUE_STATUS
    |=> rdata == {$past(receive_queue_overrun),
                  $past(receive_queue_count)})
    else $error("queue status read wrong");

  chk_fixed_bits: assert property (
    @(posedge clk) disable iff (reset)
    rd && addr == rpsr_pkg::ADDR_PACKET_LINE_STATUS
    |=> rdata[rpsr_pkg::BIT_UNUSED] == 1'b0
        && rdata[rpsr_pkg::BIT_RSVD_HI:rpsr_pkg::BIT_RSVD_LO]
           == rpsr_pkg::RSVD_VALUE)
    else $error("fixed bits wrong");

  chk_read_one_cycle: assert property (
    @(posedge clk) disable iff (reset)
    !rd |=> rdata == rpsr_pkg::ZERO_BYTE)
    else $error("read data not zero outside read slot");

  chk_unmapped_read: assert property (
    @(posedge clk) disable iff (reset)
    rd && addr != rpsr_pkg::ADDR_PACKET_LINE_STATUS
       && addr != rpsr_pkg::ADDR_RECEIVE_QUEUE_STATUS
       && addr != rpsr_pkg::ADDR_IRQ_STATUS
       && addr != rpsr_pkg::ADDR_IRQ_MASK
    |=> rdata == rpsr_pkg::ZERO_BYTE)
    else $error("unmapped read not zero");

  // Interrupt registers
  chk_irq_checksum_set: assert property (
    @(posedge clk) disable iff (reset)
    checksum_done && checksum_match
    |=> irq_status[rpsr_pkg::IRQ_CHECKSUM_OK])
    else $error("checksum event not latched in interrupt status");

  chk_irq_clear: assert property (
    @(posedge clk) disable iff (reset)
    wr && addr == rpsr_pkg::ADDR_IRQ_STATUS && irq_event == rpsr_pkg::IRQ_RESET
    |=> (irq_status & $past(wdata[IRQ_W-1:0])) == rpsr_pkg::IRQ_RESET)
    else $error("interrupt status not cleared by write of one");

  chk_irq_mask_write: assert property (
    @(posedge clk) disable iff (reset)
    wr && addr == rpsr_pkg::ADDR_IRQ_MASK
    |=> irq_mask == $past(wdata[IRQ_W-1:0]))
    else $error("interrupt mask not written");

  // Coverage of the main scenarios
  cov_frame: cover property (
    @(posedge clk) disable iff (reset)
    sync_found ##[1:50] packet_end);

  cov_overrun: cover property (
    @(posedge clk) disable iff (reset)
    frame_start_flag ##1 receive_queue_overrun);

  cov_irq: cover property (
    @(posedge clk) disable iff (reset)
    !irq ##1 irq);

  cov_irq_clear: cover property (
    @(posedge clk) disable iff (reset)
    irq ##1 !irq);

  cov_checksum_fail: cover property (
    @(posedge clk) disable iff (reset)
    checksum_done && !checksum_match);

endmodule : rpsr_status_regs

// *** tb/rpsr_host.sv ***
`timescale 1ns/1ps
module rpsr_host
(
  input  wire logic       clk,   // Bus clock
  input  wire logic [7:0] rdata, // Read data from device
  output logic      [7:0] addr,  // Register address
  output logic      [7:0] wdata, // Write data
  output logic            wr,    // Write strobe
  output logic            rd     // Read strobe
);
  // Pin bits are polled as levels only, never as a lock indication
  initial
  begin
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
  end
  task wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  // Data stands one cycle only, so it is taken just after its edge
  task rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg
endmodule : rpsr_host

// *** tb/rpsr_status_regs_test.sv ***
`timescale 1ns/1ps
module rpsr_status_regs_test;
  logic clk, reset, irq, car, ovr, g2, g0;
  logic [7:0] addr, wdata, rdata, d;
  logic wr, rd, mt;
  logic [5:0] ev;
  logic [6:0] cnt;
  int miscompares, checks_done;
  rpsr_host u_rpsr_host (.clk(clk), .rdata(rdata), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd));
  rpsr_status_regs u_rpsr_status_regs (.clk(clk), .reset(reset),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq),
    .checksum_done(ev[0]), .checksum_match(mt), .rx_enter(ev[1]),
    .carrier_detect(car), .radio_idle_enter(ev[2]), .sync_found(ev[3]),
    .packet_end(ev[4]), .packet_drop(ev[5]), .receive_queue_overrun(ovr),
    .receive_queue_count(cnt), .general_output_two(g2),
    .general_output_zero(g0));
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task wrap_up;
    if (miscompares == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : wrap_up
  task chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task rx(input logic [7:0] a, input logic [7:0] e);
    u_rpsr_host.rd_reg(a, d);
    chk(d, e);
  endtask : rx
  task pulse(input logic [5:0] m);
    @(posedge clk);
    ev <= m;
    @(posedge clk);
    ev <= 6'h00;
  endtask : pulse
  task t_flags;
    pulse(6'h01);
    rx(8'h38, 8'h80);
    pulse(6'h02);
    rx(8'h38, 8'h00);
    pulse(6'h01);
    mt <= 1'b0;
    pulse(6'h01);
    rx(8'h38, 8'h00);
    mt <= 1'b1;
    car <= 1'b1;
    rx(8'h38, 8'h40);
    pulse(6'h04);
    car <= 1'b0;
    rx(8'h38, 8'h00);
    pulse(6'h08);
    rx(8'h38, 8'h08);
    pulse(6'h10);
    rx(8'h38, 8'h00);
    pulse(6'h08);
    pulse(6'h20);
    rx(8'h38, 8'h00);
    pulse(6'h08);
    ovr <= 1'b1;
    rx(8'h38, 8'h00);
  endtask : t_flags
  task t_queue_pins;
    cnt <= 7'h7F;
    rx(8'h3B, 8'hFF);
    ovr <= 1'b0;
    rx(8'h3B, 8'h7F);
    g2 <= 1'b1;
    g0 <= 1'b1;
    repeat (3) @(posedge clk);
    rx(8'h38, 8'h05);
    g0 <= 1'b0;
    repeat (3) @(posedge clk);
    rx(8'h38, 8'h04);
    u_rpsr_host.wr_reg(8'h38, 8'hFF);
    u_rpsr_host.wr_reg(8'h3B, 8'h00);
    rx(8'h38, 8'h04);
    rx(8'h3B, 8'h7F);
    rx(8'h10, 8'h00);
  endtask : t_queue_pins
  task t_irq;
    u_rpsr_host.wr_reg(8'h40, 8'h0F);
    u_rpsr_host.wr_reg(8'h41, 8'h01);
    #1 chk({7'h00, irq}, 8'h00);
    pulse(6'h01);
    rx(8'h40, 8'h01);
    chk({7'h00, irq}, 8'h01);
    pulse(6'h08);
    rx(8'h40, 8'h03);
    u_rpsr_host.wr_reg(8'h40, 8'h01);
    rx(8'h40, 8'h02);
    chk({7'h00, irq}, 8'h00);
    rx(8'h41, 8'h01);
  endtask : t_irq
  initial
  begin
    miscompares = 0;
    checks_done = 0;
    {reset, car, ovr, g2, g0} = 5'h10;
    ev = 6'h00;
    mt = 1'b1;
    cnt = 7'h00;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    rx(8'h38, 8'h00);
    rx(8'h3B, 8'h00);
    t_flags();
    t_queue_pins();
    t_irq();
    wrap_up();
  end
  initial
  begin
    #200us;
    miscompares++;
    wrap_up();
  end
endmodule : rpsr_status_regs_test
